// ===== usb_sig_pkg.sv
// Purpose: constants and types shared by the usb line-state checker
// Assumes: sampling clock of 200 MHz; times kept in ps or ns as named
// Notes:   least times round up to cycles, longest times round down
package usb_sig_pkg;

   // ---------------------------------------------------------------
   // clock and widths
   // ---------------------------------------------------------------
   localparam longint CLK_PS = 5000;
   localparam longint CLK_NS = 5;
   localparam int CNT_W = 24;
   localparam int CODE_W = 24;

   function automatic longint ceil_div(input longint a, input longint b);
      return (a + b - 1) / b;
   endfunction

   // ---------------------------------------------------------------
   // line timing
   // ---------------------------------------------------------------
   localparam longint SE0_MIN_PS = 80000;
   localparam longint FS_BIT_PS = 83333;
   localparam longint LS_BIT_PS = 666667;
   localparam longint RST_MIN_NS = 10000000;
   localparam longint RES_MIN_NS = 20000000;
   localparam longint RES_DET_BITS = 8;

   localparam logic [CNT_W-1:0] SE0_MIN_CYC = CNT_W'(ceil_div(SE0_MIN_PS, CLK_PS));
   localparam logic [CNT_W-1:0] FS_HALF_CYC = CNT_W'(ceil_div(FS_BIT_PS / 2, CLK_PS));
   localparam logic [CNT_W-1:0] LS_HALF_CYC = CNT_W'(ceil_div(LS_BIT_PS / 2, CLK_PS));
   localparam logic [CNT_W-1:0] FS_25_CYC = CNT_W'((FS_BIT_PS * 5 / 2) / CLK_PS);
   localparam logic [CNT_W-1:0] LS_BIT_CYC = CNT_W'(ceil_div(LS_BIT_PS, CLK_PS));
   localparam logic [CNT_W-1:0] LS_25_CYC = CNT_W'((LS_BIT_PS * 5 / 2) / CLK_PS);
   localparam logic [CNT_W-1:0] RES_DET_CYC =
      CNT_W'(ceil_div(LS_BIT_PS * RES_DET_BITS, CLK_PS));
   localparam logic [CNT_W-1:0] RST_MIN_CYC_DEF = CNT_W'(RST_MIN_NS / CLK_NS);
   localparam logic [CNT_W-1:0] RES_MIN_CYC_DEF = CNT_W'(ceil_div(RES_MIN_NS, CLK_NS));
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   // ---------------------------------------------------------------
   // line states and error numbers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_SE0, ST_J, ST_K, ST_SE1} line_e;

   localparam logic [3:0] D_NONE = 4'h0;
   localparam logic [3:0] D_SE0_SHORT = 4'h1;
   localparam logic [3:0] D_SE0_FS_LS = 4'h2;
   localparam logic [3:0] D_SE0_LS_RST = 4'h3;
   localparam logic [3:0] D_EOP_LONG = 4'h4;
   localparam logic [3:0] D_K_AFTER_SE0 = 4'h5;
   localparam logic [3:0] D_J_SHORT = 4'h6;
   localparam logic [3:0] D_RES_SHORT = 4'h7;
   localparam logic [3:0] D_K_SHORT = 4'h8;
   localparam logic [3:0] D_REOP_SHORT = 4'h9;
   localparam logic [3:0] D_REOP_LONG = 4'hA;
   localparam logic [3:0] D_FS_EOP_LS = 4'hB;
   localparam logic [15:0] PV_SIG_CLASS = 16'h0100;

   // printed code digits as bcd: number n gives 0x0100nn
   function automatic logic [CODE_W-1:0] pv_code(input logic [3:0] n);
      logic [3:0] lo;
      lo = (n >= 4'hA) ? 4'(n - 4'hA) : n;
      return {PV_SIG_CLASS, (n >= 4'hA) ? 4'h1 : 4'h0, lo};
   endfunction

endpackage

// ===== usb_signaling_error_checker.sv
// Purpose: classify observed usb line states by duration, flag signaling errors
// Assumes: dp/dm samples synchronous to clk; low_speed gives the bus speed
// Notes:   one record per ended line state at most
// Notes on behaviour
// - se0 shorter than 80 ns reports code 010001
// - se0 above 5/2 fs bit and below one ls bit on a full-speed bus reports 010002
// - se0 between 5/2 ls bits and 10 ms ending in se1 reports 010003
// - eop longer than 5/2 ls bits reports 010004
// - k directly after se0 reports 010005
// - j shorter than half the current bit time reports 010006
// - resume k shorter than 20 ms reports 010007
// - k shorter than half the current bit time reports 010008
// - ls eop closing resume shorter than one ls bit reports 010009
// - ls eop closing resume above 5/2 ls bits reports 010010
// - full-speed length eop on a low-speed bus reports 010011
// - each record carries a pv code and a description number
// - each record carries the index of the offending bus event
`timescale 1ns/1ps
module usb_signaling_error_checker #(
   parameter int EVT_W = 32,
   parameter logic [usb_sig_pkg::CNT_W-1:0] RST_MIN_CYC = usb_sig_pkg::RST_MIN_CYC_DEF,
   parameter logic [usb_sig_pkg::CNT_W-1:0] RES_MIN_CYC = usb_sig_pkg::RES_MIN_CYC_DEF
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic line_dp,
   input wire logic line_dm,
   input wire logic low_speed,
   output logic err_valid,
   output logic [usb_sig_pkg::CODE_W-1:0] err_code,
   output logic [3:0] err_desc,
   output logic [EVT_W-1:0] err_event
);
   import usb_sig_pkg::*;

   // ---------------------------------------------------------------
   // line state decode and duration count
   // ---------------------------------------------------------------
   line_e smp_state;
   line_e cur_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [EVT_W-1:0] event_idx_ff;
   logic resume_ff;
   logic nxt_resume;
   logic change;
   logic [CNT_W-1:0] half_cyc;

   // full speed: dp high is j; low speed: dm high is j
   assign smp_state = (!line_dp && !line_dm) ? ST_SE0 :
                      (line_dp && line_dm) ? ST_SE1 :
                      (line_dp ^ low_speed) ? ST_J : ST_K;
   assign change = smp_state != cur_ff;
   assign half_cyc = low_speed ? LS_HALF_CYC : FS_HALF_CYC;
   assign nxt_cnt = change ? CNT_ONE :
                    (&cnt_ff) ? cnt_ff : CNT_W'(cnt_ff + CNT_ONE);

   // ---------------------------------------------------------------
   // classification of the ended state
   // ---------------------------------------------------------------
   logic se0_end;
   logic j_end;
   logic k_end;
   logic to_j;
   logic res_k;
   logic e1, e2, e3, e4, e5, e6, e7, e8, e9, e10, e11;
   logic [3:0] nxt_desc;

   assign se0_end = change && cur_ff == ST_SE0;
   assign j_end = change && cur_ff == ST_J;
   assign k_end = change && cur_ff == ST_K;
   assign to_j = smp_state == ST_J;
   assign res_k = cnt_ff >= RES_DET_CYC;

   assign e1 = se0_end && cnt_ff < SE0_MIN_CYC;
   assign e9 = se0_end && resume_ff && to_j && cnt_ff < LS_BIT_CYC;
   assign e10 = se0_end && resume_ff && to_j && cnt_ff > LS_25_CYC;
   assign e5 = se0_end && smp_state == ST_K;
   assign e11 = se0_end && low_speed && to_j && cnt_ff <= FS_25_CYC;
   assign e2 = se0_end && !low_speed && cnt_ff > FS_25_CYC
               && cnt_ff < LS_BIT_CYC;
   assign e4 = se0_end && to_j && cnt_ff > LS_25_CYC;
   assign e3 = se0_end && !to_j && cnt_ff > LS_25_CYC
               && cnt_ff < RST_MIN_CYC;
   assign e7 = k_end && res_k && cnt_ff < RES_MIN_CYC;
   assign e8 = k_end && cnt_ff < half_cyc;
   assign e6 = j_end && cnt_ff < half_cyc;

   // one code per ended state, in fixed priority
   assign nxt_desc = e1 ? D_SE0_SHORT :
                     e9 ? D_REOP_SHORT :
                     e10 ? D_REOP_LONG :
                     e5 ? D_K_AFTER_SE0 :
                     e11 ? D_FS_EOP_LS :
                     e2 ? D_SE0_FS_LS :
                     e4 ? D_EOP_LONG :
                     e3 ? D_SE0_LS_RST :
                     e7 ? D_RES_SHORT :
                     e8 ? D_K_SHORT :
                     e6 ? D_J_SHORT : D_NONE;

   // resume k arms the check of the closing eop
   assign nxt_resume = (k_end && res_k) ? 1'b1 :
                       se0_end ? 1'b0 : resume_ff;

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cur_ff <= ST_J;
         cnt_ff <= CNT_ONE;
         resume_ff <= 1'b0;
      end else begin
         cur_ff <= smp_state;
         cnt_ff <= nxt_cnt;
         resume_ff <= nxt_resume;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         event_idx_ff <= '0;
      end else if (change) begin
         event_idx_ff <= EVT_W'(event_idx_ff + 1'b1);
      end
   end

   // ---------------------------------------------------------------
   // error record
   // ---------------------------------------------------------------
   logic err_valid_ff;
   logic [CODE_W-1:0] err_code_ff;
   logic [3:0] err_desc_ff;
   logic [EVT_W-1:0] err_event_ff;
   logic hit;

   assign hit = nxt_desc != D_NONE;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         err_valid_ff <= 1'b0;
      end else begin
         err_valid_ff <= hit;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         err_code_ff <= '0;
         err_desc_ff <= D_NONE;
         err_event_ff <= '0;
      end else if (hit) begin
         err_code_ff <= pv_code(nxt_desc);
         err_desc_ff <= nxt_desc;
         err_event_ff <= event_idx_ff;
      end
   end

   assign err_valid = err_valid_ff;
   assign err_code = err_code_ff;
   assign err_desc = err_desc_ff;
   assign err_event = err_event_ff;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_se0_short_code: assert property (
      se0_end && cnt_ff < SE0_MIN_CYC |=> err_valid && err_code == 24'h010001)
      else $error("short se0 not flagged");

   a_se0_mid_code: assert property (
      $past(se0_end && !low_speed && !resume_ff && smp_state != ST_K)
      && $past(cnt_ff) > FS_25_CYC && $past(cnt_ff) < LS_BIT_CYC
      |-> err_valid && err_desc == D_SE0_FS_LS)
      else $error("se0 between fs and ls bit not flagged");

   a_se0_long_code: assert property (
      se0_end && smp_state == ST_SE1 && cnt_ff > LS_25_CYC && cnt_ff < RST_MIN_CYC
      |=> err_valid && err_code == 24'h010003)
      else $error("long se0 not flagged");

   a_eop_long_code: assert property (
      se0_end && to_j && !resume_ff && cnt_ff > LS_25_CYC
      |=> err_valid && err_code == 24'h010004)
      else $error("long eop not flagged");

   a_k_after_se0: assert property (
      se0_end && smp_state == ST_K && cnt_ff >= SE0_MIN_CYC
      |=> err_valid && err_code == 24'h010005)
      else $error("k after se0 not flagged");

   a_j_short_code: assert property (
      j_end && cnt_ff < half_cyc |=> err_valid && err_desc == D_J_SHORT)
      else $error("short j not flagged");

   a_resume_short: assert property (
      k_end && cnt_ff >= RES_DET_CYC && cnt_ff < RES_MIN_CYC
      |=> err_valid && err_code == 24'h010007)
      else $error("short resume not flagged");

   a_k_short_code: assert property (
      k_end && cnt_ff < half_cyc |=> err_valid && err_desc == D_K_SHORT)
      else $error("short k not flagged");

   a_reop_short: assert property (
      se0_end && resume_ff && to_j && cnt_ff >= SE0_MIN_CYC && cnt_ff < LS_BIT_CYC
      |=> err_code == 24'h010009)
      else $error("short resume eop not flagged");

   a_reop_long: assert property (
      se0_end && resume_ff && to_j && cnt_ff > LS_25_CYC
      |=> err_code == 24'h010010)
      else $error("long resume eop not flagged");

   a_fs_eop_ls: assert property (
      se0_end && low_speed && !resume_ff && to_j && cnt_ff >= SE0_MIN_CYC
      && cnt_ff <= FS_25_CYC |=> err_valid && err_code == 24'h010011)
      else $error("fs eop on ls bus not flagged");

   a_code_class: assert property (
      err_valid |-> err_code[23:8] == 16'h0100 && err_desc != D_NONE)
      else $error("record without pv class");

   a_event_index: assert property (
      err_valid |-> err_event == EVT_W'($past(event_idx_ff)))
      else $error("record holds wrong event index");

   a_quiet_no_err: assert property (
      !change |=> !err_valid)
      else $error("error reported while state still running");

   a_fs_eop_clean: assert property (
      se0_end && !low_speed && !resume_ff && to_j && cnt_ff >= SE0_MIN_CYC
      && cnt_ff <= FS_25_CYC |=> !err_valid)
      else $error("legal fs eop flagged");

   a_ls_eop_clean: assert property (
      se0_end && low_speed && !resume_ff && to_j && cnt_ff > FS_25_CYC
      && cnt_ff <= LS_25_CYC |=> !err_valid)
      else $error("legal ls eop flagged");

   a_j_long_quiet: assert property (
      j_end && cnt_ff >= half_cyc |=> !err_valid)
      else $error("legal j flagged");

   a_k_long_quiet: assert property (
      k_end && cnt_ff >= half_cyc && !res_k |=> !err_valid)
      else $error("legal k flagged");

   a_resume_ok: assert property (
      k_end && cnt_ff >= RES_MIN_CYC |=> !err_valid)
      else $error("long resume flagged");

   a_resume_arm: assert property (
      k_end && res_k |=> resume_ff)
      else $error("resume k did not arm eop check");

   a_resume_clear: assert property (
      se0_end |=> !resume_ff)
      else $error("eop check stayed armed");

   a_reop_clean: assert property (
      se0_end && resume_ff && to_j && cnt_ff >= LS_BIT_CYC && cnt_ff <= LS_25_CYC
      |=> !err_valid)
      else $error("legal resume eop flagged");

   a_event_step: assert property (
      change |=> event_idx_ff == EVT_W'($past(event_idx_ff) + 1'b1))
      else $error("event index did not step");

   a_event_hold: assert property (
      !change |=> $stable(event_idx_ff))
      else $error("event index moved without a change");

   a_count_restart: assert property (
      change |=> cnt_ff == CNT_ONE)
      else $error("duration count did not restart");

   a_count_step: assert property (
      !change && !(&cnt_ff) |=> cnt_ff == CNT_W'($past(cnt_ff) + CNT_ONE))
      else $error("duration count did not step");

   a_record_hold: assert property (
      !hit |=> $stable(err_code) && $stable(err_desc) && $stable(err_event))
      else $error("record changed without an error");

   a_desc_range: assert property (
      err_valid |-> err_desc <= D_FS_EOP_LS)
      else $error("record description out of range");

   c_se0_short: cover property (se0_end && cnt_ff < SE0_MIN_CYC ##1 err_valid);
   c_resume_eop: cover property (k_end && res_k ##[1:1000] se0_end && to_j);
   c_k_short: cover property (k_end ##1 err_desc == D_K_SHORT);
   c_clean_eop: cover property (se0_end && to_j && !e4 && !e11);
   c_resume_ok: cover property (k_end && cnt_ff >= RES_MIN_CYC);

endmodule

// ===== usb_bus_model.sv
// Purpose: far-side bus model, puts a line state on the sampled d+/d- pair
// Assumes: j is dp high on full speed and dm high on low speed
// Notes:   the bench picks the state; se1 drives both lines high
`timescale 1ns/1ps
module usb_bus_model (
   input wire logic low_speed,
   input wire usb_sig_pkg::line_e st,
   output logic line_dp,
   output logic line_dm
);
   import usb_sig_pkg::*;
   wire logic j_on_dp = ~low_speed;
   wire logic is_j = (st == ST_J);
   wire logic is_k = (st == ST_K);
   wire logic is_se1 = (st == ST_SE1);
   assign line_dp = is_se1 | (is_j & j_on_dp) | (is_k & ~j_on_dp);
   assign line_dm = is_se1 | (is_j & ~j_on_dp) | (is_k & j_on_dp);
endmodule

// ===== testbench.sv
// Purpose: self-checking bench for the usb line-state checker
// Assumes: short reset and resume limits of 2000 and 3000 cycles
// Notes:   records are queued by a monitor and popped by each scenario
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin \
   num_checks++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("[FAIL] %0t %s", $time, msg); \
   end \
end
module testbench;
   import usb_sig_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic low_speed = 1'b0;
   line_e st = ST_J;
   wire logic line_dp;
   wire logic line_dm;
   wire logic err_valid;
   wire logic [CODE_W-1:0] err_code;
   wire logic [3:0] err_desc;
   wire logic [31:0] err_event;
   int n_errors = 0;
   int num_checks = 0;
   int n_chg = 0;
   logic [3:0] q_desc[$];
   logic [CODE_W-1:0] q_code[$];
   logic [31:0] q_evt[$];

   usb_bus_model i_usb_bus_model (.low_speed(low_speed), .st(st), .line_dp(line_dp),
      .line_dm(line_dm));
   usb_signaling_error_checker #(.EVT_W(32), .RST_MIN_CYC(24'h0007D0),
      .RES_MIN_CYC(24'h000BB8)) i_usb_signaling_error_checker (.clk(clk), .rstn(rstn),
      .line_dp(line_dp), .line_dm(line_dm), .low_speed(low_speed), .err_valid(err_valid),
      .err_code(err_code), .err_desc(err_desc), .err_event(err_event));

   initial begin
      forever #2.5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // record monitor and shared tasks
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      if (err_valid === 1'b1) begin
         q_desc.push_back(err_desc);
         q_code.push_back(err_code);
         q_evt.push_back(err_event);
      end
   end

   task automatic do_reset(input logic ls);
      rstn = 1'b0;
      low_speed = ls;
      st = ST_J;
      n_chg = 0;
      repeat (3) @(negedge clk);
      `CHK(err_valid, 1'b0, "valid in reset")
      `CHK(err_code, 24'h000000, "code in reset")
      rstn = 1'b1;
      repeat (80) @(negedge clk);
   endtask

   task automatic drv(input line_e s, input int n);
      if (s != st) n_chg++;
      st = s;
      repeat (n) @(negedge clk);
   endtask

   task automatic check(input logic [3:0] d, input logic [CODE_W-1:0] c);
      `CHK(q_desc.size() > 0, 1'b1, "record missing")
      if (q_desc.size() > 0) begin
         `CHK(q_desc[0], d, "description")
         `CHK(q_code[0], c, "code")
         `CHK(q_evt[0], 32'(n_chg - 1), "event index")
         void'(q_desc.pop_front());
         void'(q_code.pop_front());
         void'(q_evt.pop_front());
      end
   endtask

   task automatic done();
      `CHK(q_desc.size(), 0, "unexpected record")
      q_desc.delete();
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_se0_short();
      drv(ST_SE0, 15);
      drv(ST_J, 80);
      check(4'h1, 24'h010001);
      drv(ST_SE0, 16);
      drv(ST_J, 80);
      done();
   endtask

   task automatic t_se0_mid();
      drv(ST_SE0, 41);
      drv(ST_J, 80);
      done();
      drv(ST_SE0, 42);
      drv(ST_J, 80);
      check(4'h2, 24'h010002);
   endtask

   task automatic t_se0_long();
      drv(ST_SE0, 333);
      drv(ST_J, 80);
      done();
      drv(ST_SE0, 334);
      drv(ST_J, 80);
      check(4'h4, 24'h010004);
      drv(ST_SE0, 400);
      drv(ST_SE1, 5);
      check(4'h3, 24'h010003);
      drv(ST_J, 80);
      done();
   endtask

   task automatic t_k_cases();
      drv(ST_SE0, 20);
      drv(ST_K, 80);
      check(4'h5, 24'h010005);
      drv(ST_J, 80);
      drv(ST_K, 8);
      drv(ST_J, 80);
      check(4'h8, 24'h010008);
      drv(ST_K, 80);
      drv(ST_J, 8);
      drv(ST_K, 80);
      check(4'h6, 24'h010006);
      drv(ST_J, 80);
      done();
   endtask

   task automatic t_low_speed();
      drv(ST_SE0, 20);
      drv(ST_J, 80);
      check(4'hB, 24'h010011);
      drv(ST_SE0, 60);
      drv(ST_J, 80);
      done();
      drv(ST_K, 80);
      drv(ST_J, 66);
      drv(ST_K, 80);
      check(4'h6, 24'h010006);
      drv(ST_J, 80);
      done();
   endtask

   task automatic t_resume();
      drv(ST_K, 1100);
      drv(ST_SE0, 100);
      check(4'h7, 24'h010007);
      drv(ST_J, 80);
      check(4'h9, 24'h010009);
      drv(ST_K, 1100);
      drv(ST_SE0, 200);
      check(4'h7, 24'h010007);
      drv(ST_J, 80);
      done();
      drv(ST_K, 1100);
      drv(ST_SE0, 400);
      check(4'h7, 24'h010007);
      drv(ST_J, 80);
      check(4'hA, 24'h010010);
      drv(ST_K, 3000);
      drv(ST_J, 80);
      done();
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_errors++;
      $display("[FAIL] %0t run limit reached", $time);
      summarize();
   end

   initial begin
      do_reset(1'b0);
      t_se0_short();
      t_se0_mid();
      t_se0_long();
      t_k_cases();
      do_reset(1'b1);
      t_low_speed();
      t_resume();
      summarize();
   end
endmodule
